// File: pwl_lock_core.sv
// parameter password lock: access guard for the drive parameter store
// Operation
// - lock level takes 1-6 or 101-106; 9999, the reset value, means no lock
// - locked levels 1/2/3 (+100) block writes: both, local, network sides
// - locked levels 4/5/6 (+100) block reads and writes: both, local, network
// - permitted read still refused when extended display hides the parameter
// - permitted write still refused when write selection forbids it
// - network restrictions for RS-485 net mode, local for the local source
// - levels 101-106 count unlock errors 0-5; levels 1-6 read back 0
// - after five errors at a counting level correct password does not unlock
// - password registers only from 1000 to 9998, then restriction applies
// - password entry write refused while lock level holds 9999, except 0 and 9999
// - once registered, password entry reads back the error count only
// - refused access to restricted parameter raises a dedicated error flag
// - internal drive updates of parameters proceed regardless of lock
// - correct password unlocks; wrong one raises error, lock stays
// - all-parameter clear releases lock and reinitialises every parameter
// - all-parameter clear refused while the drive runs
// - writing 0 or 9999 to password entry accepted with no effect
// - entry writable when locked; unlocked, only with extended display on
// - easy-mode operation switching unavailable while local writes locked
// - local jog unavailable at levels 4, 5, 104, 105 while locked
// - parameter copy from parameter unit refused while locked
`timescale 1ns/10ps
`default_nettype none
`include "pwl_consts.svh"

module pwl_lock_core (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_sel,
  input  wire logic        req_net,
  input  wire logic [15:0] req_wdata,
  input  wire logic        par_hidden,
  input  wire logic        ext_display_on,
  input  wire logic        write_sel_permits,
  input  wire logic        drive_running,
  input  wire logic        internal_wr,
  input  wire logic        all_clear_req,
  input  wire logic        par_clear_req,
  input  wire logic        copy_req,
  output logic             resp_valid,
  output logic             resp_granted,
  output logic             resp_refused,
  output logic [15:0]      resp_rdata,
  output logic             lock_error_shown,
  output logic             unlock_error,
  output logic             internal_wr_go,
  output logic             all_clear_go,
  output logic             par_clear_go,
  output logic             copy_go,
  output logic             lock_active,
  output logic [15:0]      lock_restriction_level,
  output logic             easy_mode_allow,
  output logic             local_jog_allow
);

  // ==========================================================
  // state
  // ==========================================================
  pwl_pkg::pwl_state_t   st;
  pwl_pkg::pwl_state_t   next_st;
  logic [15:0]           pw_stored;
  logic [`PWL_ERR_W-1:0] err_cnt;

  // ==========================================================
  // level decode, current setting and incoming value
  // ==========================================================
  wire cur_legal;
  wire cur_counting;
  wire cur_loc_rd_blk;
  wire cur_loc_wr_blk;
  wire cur_net_rd_blk;
  wire cur_net_wr_blk;
  wire new_legal;

  pwl_level_decode u_cur (
    .level      (lock_restriction_level),
    .legal      (cur_legal),
    .counting   (cur_counting),
    .loc_rd_blk (cur_loc_rd_blk),
    .loc_wr_blk (cur_loc_wr_blk),
    .net_rd_blk (cur_net_rd_blk),
    .net_wr_blk (cur_net_wr_blk)
  );

  pwl_level_decode u_new (
    .level      (req_wdata),
    .legal      (new_legal),
    .counting   (),
    .loc_rd_blk (),
    .loc_wr_blk (),
    .net_rd_blk (),
    .net_wr_blk ()
  );

  // ==========================================================
  // request classification
  // ==========================================================
  wire locked;
  wire no_lock_cfg;
  wire rd;
  wire wr;
  wire sel_other;
  wire sel_level;
  wire sel_entry;
  wire side_rd_blk;
  wire side_wr_blk;

  assign locked      = (st != pwl_pkg::pwl_st_open);
  assign no_lock_cfg = (lock_restriction_level == `PWL_LVL_NONE);
  assign rd          = req_valid & ~req_write;
  assign wr          = req_valid & req_write;
  assign sel_other   = (req_sel == pwl_pkg::pwl_sel_other);
  assign sel_level   = (req_sel == pwl_pkg::pwl_sel_level);
  assign sel_entry   = (req_sel == pwl_pkg::pwl_sel_entry);

  // the requester's side picks which pair of block flags applies
  assign side_rd_blk = locked & (req_net ? cur_net_rd_blk : cur_loc_rd_blk);
  assign side_wr_blk = locked & (req_net ? cur_net_wr_blk : cur_loc_wr_blk);

  // ==========================================================
  // ordinary parameters
  // ==========================================================
  wire oth_rd_ok;
  wire oth_wr_ok;
  wire oth_pw_refuse;

  // password gate first, then display and write-selection gates
  assign oth_rd_ok     = ~side_rd_blk & ~par_hidden;
  assign oth_wr_ok     = ~side_wr_blk & write_sel_permits;
  assign oth_pw_refuse = sel_other &
                         ((rd & side_rd_blk) | (wr & side_wr_blk));

  // ==========================================================
  // lock level parameter
  // ==========================================================
  wire lvl_rd_ok;
  wire lvl_wr_ok;

  // the level stays frozen while a password is registered
  assign lvl_rd_ok = ~no_lock_cfg | ext_display_on;
  assign lvl_wr_ok = ~locked & ext_display_on & new_legal;

  // ==========================================================
  // password entry parameter
  // ==========================================================
  wire ent_noop;
  wire ent_in_range;
  wire ent_rd_ok;
  wire ent_act;
  wire reg_evt;
  wire pw_match;
  wire unlock_evt;
  wire bad_evt;
  wire ent_wr_ok;
  wire at_last_err;

  assign ent_noop     = (req_wdata == `PWL_PW_NOOP) || (req_wdata == `PWL_PW_RESET);
  assign ent_in_range = (req_wdata >= `PWL_PW_MIN) && (req_wdata <= `PWL_PW_MAX);
  assign ent_rd_ok    = ~no_lock_cfg | ext_display_on;
  // the no-effect values win even with no lock configured
  assign ent_act      = wr & sel_entry & ~ent_noop & ~no_lock_cfg;
  // unlocked: needs extended display; locked: always writable
  assign reg_evt      = ent_act & ~locked & ext_display_on & ent_in_range;
  assign pw_match     = (req_wdata == pw_stored);
  assign unlock_evt   = ent_act & (st == pwl_pkg::pwl_st_locked) & pw_match;
  assign bad_evt      = ent_act & locked & (~pw_match | (st == pwl_pkg::pwl_st_jammed));
  assign ent_wr_ok    = (wr & sel_entry & ent_noop) | reg_evt | unlock_evt;
  assign at_last_err  = cur_counting && (err_cnt == (`PWL_ERR_MAX - 3'h1));

  // ==========================================================
  // answer selection
  // ==========================================================
  wire        req_ok;
  wire [15:0] rd_value;
  wire [15:0] ent_value;

  assign req_ok = sel_other ? (rd ? oth_rd_ok : oth_wr_ok) :
                  sel_level ? (rd ? lvl_rd_ok : lvl_wr_ok) :
                  sel_entry ? (rd ? ent_rd_ok : ent_wr_ok) : 1'b0;

  // registered password never leaves the block, only the error count
  assign ent_value = locked ? {13'h0000, (cur_counting ? err_cnt : 3'h0)}
                            : `PWL_PW_RESET;
  assign rd_value  = ~rd ? 16'h0000 :
                     sel_level ? lock_restriction_level :
                     sel_entry ? ent_value : 16'h0000;

  // ==========================================================
  // next lock state
  // ==========================================================
  wire clr_ok;

  assign clr_ok = all_clear_req & ~drive_running;

  always_comb begin
    next_st = st;
    unique case (st)
      pwl_pkg::pwl_st_open: begin
        if (reg_evt) begin
          next_st = pwl_pkg::pwl_st_locked;
        end
      end
      pwl_pkg::pwl_st_locked: begin
        if (unlock_evt) begin
          next_st = pwl_pkg::pwl_st_open;
        end else if (bad_evt && at_last_err) begin
          next_st = pwl_pkg::pwl_st_jammed;
        end
      end
      pwl_pkg::pwl_st_jammed: begin
        next_st = pwl_pkg::pwl_st_jammed;
      end
      default: begin
        next_st = pwl_pkg::pwl_st_open;
      end
    endcase
    if (clr_ok) begin
      next_st = pwl_pkg::pwl_st_open;
    end
  end

  // ==========================================================
  // lock registers
  // ==========================================================
  // all clear has priority over any request in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st                     <= pwl_pkg::pwl_st_open;
      lock_restriction_level <= `PWL_LVL_NONE;
      pw_stored              <= `PWL_PW_RESET;
      err_cnt                <= 3'h0;
    end else begin
      st <= next_st;
      if (clr_ok) begin
        lock_restriction_level <= `PWL_LVL_NONE;
        pw_stored              <= `PWL_PW_RESET;
        err_cnt                <= 3'h0;
      end else begin
        if (wr && sel_level && lvl_wr_ok) begin
          lock_restriction_level <= req_wdata;
        end
        if (reg_evt) begin
          pw_stored <= req_wdata;
          err_cnt   <= 3'h0;
        end else if (unlock_evt) begin
          err_cnt <= 3'h0;
        end else if (bad_evt && cur_counting && (err_cnt < `PWL_ERR_MAX)) begin
          err_cnt <= err_cnt + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // request answer registers
  // ==========================================================
  // one answer per request, one cycle after it is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resp_valid       <= 1'b0;
      resp_granted     <= 1'b0;
      resp_refused     <= 1'b0;
      resp_rdata       <= 16'h0000;
      lock_error_shown <= 1'b0;
      unlock_error     <= 1'b0;
    end else begin
      resp_valid       <= req_valid;
      resp_granted     <= req_valid & req_ok;
      resp_refused     <= req_valid & ~req_ok;
      resp_rdata       <= (req_valid && req_ok) ? rd_value : 16'h0000;
      lock_error_shown <= oth_pw_refuse;
      unlock_error     <= bad_evt;
    end
  end

  // ==========================================================
  // side operations
  // ==========================================================
  // internal writes bypass the lock so wear counters stay current
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      internal_wr_go <= 1'b0;
      all_clear_go   <= 1'b0;
      par_clear_go   <= 1'b0;
      copy_go        <= 1'b0;
    end else begin
      internal_wr_go <= internal_wr;
      all_clear_go   <= clr_ok;
      par_clear_go   <= par_clear_req & ~locked;
      copy_go        <= copy_req & ~locked;
    end
  end

  // ==========================================================
  // status toward the panel logic
  // ==========================================================
  assign lock_active     = locked;
  assign easy_mode_allow = ~(locked & cur_loc_wr_blk);
  assign local_jog_allow = ~(locked & cur_loc_rd_blk);

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking ast_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_LEVEL_ILLEGAL: assert property (
    (wr && sel_level && !new_legal) |=> (resp_refused && !resp_granted))
    else $error("illegal lock level accepted");
  AST_WRITE_ONLY_LEVEL: assert property (
    (rd && sel_other && locked && !par_hidden && !cur_loc_rd_blk && !cur_net_rd_blk)
    |=> resp_granted)
    else $error("read refused at a write-only restriction level");
  AST_FULL_BLOCK: assert property (
    (req_valid && sel_other && locked && cur_loc_rd_blk && cur_net_rd_blk)
    |=> (resp_refused && lock_error_shown))
    else $error("access passed at a full-block level");
  AST_HIDDEN_READ: assert property (
    (rd && sel_other && par_hidden) |=> resp_refused)
    else $error("hidden parameter read granted");
  AST_WRITE_SELECT: assert property (
    (wr && sel_other && !write_sel_permits) |=> resp_refused)
    else $error("write granted against write selection");
  AST_PLAIN_READBACK: assert property (
    (rd && sel_entry && locked && !cur_counting) |=> (resp_rdata == 16'h0000))
    else $error("non-counting level read back a nonzero count");
  AST_JAM_HOLDS: assert property (
    (st == pwl_pkg::pwl_st_jammed && !clr_ok) |=> (st == pwl_pkg::pwl_st_jammed) && lock_active)
    else $error("exhausted lock released without all clear");
  AST_NO_LOCK_ENTRY: assert property (
    (wr && sel_entry && no_lock_cfg && !ent_noop) |=> resp_refused ##1 !lock_active)
    else $error("password entry accepted with no lock level");
  AST_INTERNAL_WR: assert property (
    internal_wr |=> internal_wr_go)
    else $error("internal update blocked");
  AST_CLEAR_RUNNING: assert property (
    (all_clear_req && drive_running) |=> !all_clear_go)
    else $error("all clear performed while running");
  AST_COPY_LOCKED: assert property (
    (copy_req && locked) |=> !copy_go)
    else $error("parameter copy allowed under lock");
  AST_ERR_STEP: assert property (
    (bad_evt && cur_counting && err_cnt < `PWL_ERR_MAX && !clr_ok)
    |=> (err_cnt == $past(err_cnt) + 3'h1) && unlock_error)
    else $error("error count did not step on wrong password");

  COV_REGISTER: cover property (reg_evt ##1 lock_active);
  COV_UNLOCK:   cover property (unlock_evt ##1 !lock_active);
  COV_JAM:      cover property (st == pwl_pkg::pwl_st_jammed);
  COV_CLEAR:    cover property (locked && clr_ok ##1 all_clear_go);

endmodule
`default_nettype wire

// File: pwl_consts.svh
// constant values for the parameter password lock
`ifndef PWL_CONSTS_SVH
`define PWL_CONSTS_SVH

// restriction level encodings
`define PWL_LVL_NONE     16'h270f
`define PWL_LVL_MIN      16'h0001
`define PWL_LVL_MAX      16'h0006
`define PWL_LVL_CNT_OFS  16'h0064

// password entry encodings
`define PWL_PW_MIN       16'h03e8
`define PWL_PW_MAX       16'h270e
`define PWL_PW_NOOP      16'h0000
`define PWL_PW_RESET     16'h270f

// unlock error counter
`define PWL_ERR_MAX      3'h5
`define PWL_ERR_W        3

`endif

// File: pwl_pkg.sv
// types shared by the parameter password lock files
package pwl_pkg;

  // which parameter a request addresses
  typedef enum logic [1:0] {
    pwl_sel_other = 2'b00,
    pwl_sel_level = 2'b01,
    pwl_sel_entry = 2'b10
  } pwl_sel_t;

  // lock state: open, password registered, unlocking exhausted
  typedef enum logic [1:0] {
    pwl_st_open   = 2'b00,
    pwl_st_locked = 2'b01,
    pwl_st_jammed = 2'b10
  } pwl_state_t;

endpackage

// File: pwl_level_decode.sv
// decoder from a restriction level value to per-side block flags
`timescale 1ns/10ps
`default_nettype none
`include "pwl_consts.svh"

module pwl_level_decode (
  input  wire logic [15:0] level,
  output logic             legal,
  output logic             counting,
  output logic             loc_rd_blk,
  output logic             loc_wr_blk,
  output logic             net_rd_blk,
  output logic             net_wr_blk
);

  // ==========================================================
  // range checks
  // ==========================================================
  wire        in_plain;
  wire        in_cnt;
  wire        in_any;
  wire [15:0] base;
  wire [2:0]  idx;

  // counting levels sit 100 above the plain ones
  assign in_plain = (level >= `PWL_LVL_MIN) && (level <= `PWL_LVL_MAX);
  assign in_cnt   = (level >= (`PWL_LVL_MIN + `PWL_LVL_CNT_OFS)) &&
                    (level <= (`PWL_LVL_MAX + `PWL_LVL_CNT_OFS));
  assign in_any   = in_plain | in_cnt;
  assign base     = in_cnt ? (level - `PWL_LVL_CNT_OFS) : level;
  assign idx      = base[2:0];

  // ==========================================================
  // block flags per side
  // ==========================================================
  assign legal      = in_any | (level == `PWL_LVL_NONE);
  assign counting   = in_cnt;
  assign loc_wr_blk = in_any & ((idx == 3'h1) | (idx == 3'h2) |
                                (idx == 3'h4) | (idx == 3'h5));
  assign net_wr_blk = in_any & ((idx == 3'h1) | (idx == 3'h3) |
                                (idx == 3'h4) | (idx == 3'h6));
  assign loc_rd_blk = in_any & ((idx == 3'h4) | (idx == 3'h5));
  assign net_rd_blk = in_any & ((idx == 3'h4) | (idx == 3'h6));

endmodule
`default_nettype wire

// File: pwl_host_model.sv
// host-side requester model: operation panel, parameter unit or RS-485 host
`timescale 1ns/10ps
`default_nettype none

module pwl_host_model (
  input  wire logic        sys_clk,
  output logic             req_valid,
  output logic             req_write,
  output logic [1:0]       req_sel,
  output logic             req_net,
  output logic [15:0]      req_wdata,
  input  wire logic        resp_valid,
  input  wire logic        resp_granted,
  input  wire logic        resp_refused,
  input  wire logic [15:0] resp_rdata,
  input  wire logic        lock_error_shown,
  input  wire logic        unlock_error
);
  // ==========================================================
  // idle lines
  // ==========================================================
  // request lines quiet until the first access
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_sel = 2'b00;
    req_net = 1'b0;
    req_wdata = 16'h0000;
  end

  // ==========================================================
  // one access
  // ==========================================================
  // one-cycle strobe; answer sampled a cycle later, data then inverted
  // so a stale word can never pass for a fresh one
  task automatic access(input logic wr, input logic [1:0] sel, input logic network_side,
                        input logic [15:0] wd, output logic ok,
                        output logic [15:0] rd, output logic shown,
                        output logic uerr);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_sel = sel;
    req_net = network_side;
    req_wdata = wd;
    @(negedge sys_clk);
    req_valid = 1'b0;
    req_wdata = ~wd;
    ok = 1'bx;
    if (resp_valid === 1'b1 && resp_granted === 1'b1 && resp_refused === 1'b0) begin
      ok = 1'b1;
    end
    if (resp_valid === 1'b1 && resp_granted === 1'b0 && resp_refused === 1'b1) begin
      ok = 1'b0;
    end
    rd = resp_rdata;
    shown = lock_error_shown;
    uerr = unlock_error;
  endtask
endmodule
`default_nettype wire

// File: test_pwl_lock_core.sv
// self-checking testbench for the parameter password lock core
`timescale 1ns/10ps
`default_nettype none

module test_pwl_lock_core;
  localparam logic [1:0]  s_ord = pwl_pkg::pwl_sel_other;
  localparam logic [1:0]  s_lvl = pwl_pkg::pwl_sel_level;
  localparam logic [1:0]  s_ent = pwl_pkg::pwl_sel_entry;
  localparam logic [15:0] pw    = 16'h0bb8;
  localparam logic [15:0] bad   = 16'h0bb9;
  // per-level block masks, bit n is level n+1
  localparam logic [5:0]  lwr   = 6'b011011;
  localparam logic [5:0]  nwr   = 6'b101101;
  localparam logic [5:0]  lrd   = 6'b011000;
  localparam logic [5:0]  nrd   = 6'b101000;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid, req_write, req_net, resp_valid, resp_granted, resp_refused;
  logic [1:0]  req_sel;
  logic [15:0] req_wdata, resp_rdata, lock_restriction_level, rd;
  logic        lock_error_shown, unlock_error, lock_active, easy_mode_allow;
  logic        local_jog_allow, shown, uerr;
  logic        par_hidden = 1'b0;
  logic        ext_display_on = 1'b1;
  logic        write_sel_permits = 1'b1;
  logic        drive_running = 1'b0;
  logic [3:0]  ops = 4'h0;
  logic [3:0]  go;
  int          mismatches = 0;
  int          compares = 0;

  always #2 sys_clk = ~sys_clk;

  pwl_host_model u_pwl_host_model (.sys_clk(sys_clk), .req_valid(req_valid),
    .req_write(req_write), .req_sel(req_sel), .req_net(req_net), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_granted(resp_granted), .resp_refused(resp_refused),
    .resp_rdata(resp_rdata), .lock_error_shown(lock_error_shown),
    .unlock_error(unlock_error));

  pwl_lock_core u_pwl_lock_core (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_sel(req_sel), .req_net(req_net), .req_wdata(req_wdata),
    .par_hidden(par_hidden), .ext_display_on(ext_display_on),
    .write_sel_permits(write_sel_permits), .drive_running(drive_running),
    .internal_wr(ops[0]), .all_clear_req(ops[1]), .par_clear_req(ops[2]),
    .copy_req(ops[3]), .resp_valid(resp_valid), .resp_granted(resp_granted),
    .resp_refused(resp_refused), .resp_rdata(resp_rdata),
    .lock_error_shown(lock_error_shown), .unlock_error(unlock_error),
    .internal_wr_go(go[0]), .all_clear_go(go[1]), .par_clear_go(go[2]),
    .copy_go(go[3]), .lock_active(lock_active),
    .lock_restriction_level(lock_restriction_level),
    .easy_mode_allow(easy_mode_allow), .local_jog_allow(local_jog_allow));

  // ==========================================================
  // compare and drive helpers
  // ==========================================================
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // access through the host model, checking grant against refusal
  task automatic acc(input logic wr, input logic [1:0] sel, input logic network_side,
                     input logic [15:0] wd, input logic exp);
    logic ok;
    u_pwl_host_model.access(wr, sel, network_side, wd, ok, rd, shown, uerr);
    chk_bit(ok, exp);
  endtask

  // pulse one operation request and look for its go pulse a cycle later
  task automatic op_chk(input int i, input logic exp);
    @(negedge sys_clk);
    ops[i] = 1'b1;
    @(negedge sys_clk);
    ops[i] = 1'b0;
    chk_bit(go[i], exp);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    chk_word(lock_restriction_level, 16'h270f);
    chk_bit(lock_active, 1'b0);
    acc(1'b1, s_ent, 1'b0, pw, 1'b0);
    acc(1'b1, s_ent, 1'b0, 16'h0000, 1'b1);
    acc(1'b1, s_ent, 1'b1, 16'h270f, 1'b1);
    acc(1'b0, s_ent, 1'b0, 16'h0000, 1'b1);
    chk_word(rd, 16'h270f);
    $display("t_reset done");
  endtask

  // only 1..6, 101..106 and 9999 are taken as levels
  task automatic t_levels();
    logic [15:0] v[10] = '{16'h0000, 16'h0001, 16'h0006, 16'h0007, 16'h0064,
                           16'h0065, 16'h006a, 16'h006b, 16'h270e, 16'h270f};
    logic [9:0]  ok = 10'b0110011001;
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, s_lvl, 1'b0, v[i], ok[9-i]);
    end
    chk_word(lock_restriction_level, 16'h270f);
    acc(1'b0, s_lvl, 1'b1, 16'h0000, 1'b1);
    chk_word(rd, 16'h270f);
    $display("t_levels done");
  endtask

  task automatic t_register();
    acc(1'b1, s_lvl, 1'b0, 16'h0065, 1'b1);
    ext_display_on = 1'b0;
    acc(1'b1, s_ent, 1'b0, pw, 1'b0);
    ext_display_on = 1'b1;
    acc(1'b1, s_ent, 1'b0, 16'h03e7, 1'b0);
    acc(1'b1, s_ent, 1'b0, 16'h03e8, 1'b1);
    chk_bit(lock_active, 1'b1);
    acc(1'b0, s_ent, 1'b0, 16'h0000, 1'b1);
    chk_word(rd, 16'h0000);
    acc(1'b1, s_lvl, 1'b0, 16'h0002, 1'b0);
    ext_display_on = 1'b0;
    acc(1'b1, s_ent, 1'b0, 16'h03e9, 1'b0);
    chk_bit(uerr, 1'b1);
    acc(1'b1, s_ent, 1'b0, 16'h03e8, 1'b1);
    chk_bit(lock_active, 1'b0);
    ext_display_on = 1'b1;
    $display("t_register done");
  endtask

  // every non-counting level against both sides, reads and writes
  task automatic t_table();
    for (int l = 1; l <= 6; l++) begin
      acc(1'b1, s_lvl, 1'b0, 16'(l), 1'b1);
      acc(1'b1, s_ent, 1'b0, pw, 1'b1);
      chk_bit(easy_mode_allow, !lwr[l-1]);
      chk_bit(local_jog_allow, !lrd[l-1]);
      acc(1'b0, s_ord, 1'b0, 16'h0000, !lrd[l-1]);
      chk_bit(shown, lrd[l-1]);
      acc(1'b1, s_ord, 1'b0, 16'h0001, !lwr[l-1]);
      chk_bit(shown, lwr[l-1]);
      acc(1'b0, s_ord, 1'b1, 16'h0000, !nrd[l-1]);
      chk_bit(shown, nrd[l-1]);
      acc(1'b1, s_ord, 1'b1, 16'h0001, !nwr[l-1]);
      chk_bit(shown, nwr[l-1]);
      acc(1'b1, s_ent, 1'b0, bad, 1'b0);
      chk_bit(uerr, 1'b1);
      acc(1'b0, s_ent, 1'b0, 16'h0000, 1'b1);
      chk_word(rd, 16'h0000);
      acc(1'b1, s_ent, 1'b0, pw, 1'b1);
      chk_bit(lock_active, 1'b0);
    end
    $display("t_table done");
  endtask

  task automatic t_count();
    acc(1'b1, s_lvl, 1'b0, 16'h0066, 1'b1);
    acc(1'b1, s_ent, 1'b0, pw, 1'b1);
    for (int k = 1; k <= 5; k++) begin
      acc(1'b1, s_ent, 1'b0, bad, 1'b0);
      acc(1'b0, s_ent, 1'b0, 16'h0000, 1'b1);
      chk_word(rd, 16'(k));
    end
    acc(1'b1, s_ent, 1'b0, pw, 1'b0);
    chk_bit(lock_active, 1'b1);
    op_chk(2, 1'b0);
    op_chk(3, 1'b0);
    op_chk(0, 1'b1);
    drive_running = 1'b1;
    op_chk(1, 1'b0);
    drive_running = 1'b0;
    op_chk(1, 1'b1);
    chk_bit(lock_active, 1'b0);
    chk_word(lock_restriction_level, 16'h270f);
    $display("t_count done");
  endtask

  task automatic t_gates();
    par_hidden = 1'b1;
    acc(1'b0, s_ord, 1'b0, 16'h0000, 1'b0);
    par_hidden = 1'b0;
    write_sel_permits = 1'b0;
    acc(1'b1, s_ord, 1'b1, 16'h0001, 1'b0);
    write_sel_permits = 1'b1;
    op_chk(2, 1'b1);
    op_chk(3, 1'b1);
    $display("t_gates done");
  endtask

  // hang guard: a run that outlives this counts as failed
  initial begin
    #40000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_levels();
    t_register();
    t_table();
    t_count();
    t_gates();
    give_verdict();
  end
endmodule
`default_nettype wire
